// >>> design/adfl_pkg.sv
package adfl_pkg;

  // register port geometry
  localparam int ADFL_ADDR_W = 5;
  localparam int ADFL_DATA_W = 8;

  // register offsets
  localparam logic [4:0] ADFL_OFS_MASK = 5'h04;
  localparam logic [4:0] ADFL_OFS_FLAGS = 5'h05;

  // field positions shared by mask and flag registers
  localparam int ADFL_BIT_OVERCURRENT = 1;
  localparam int ADFL_BIT_SUPPLY_HIGH = 2;
  localparam int ADFL_BIT_SUPPLY_LOW = 3;
  localparam int ADFL_BIT_OVERTEMP = 4;
  localparam int ADFL_BIT_BUS_EDGE = 5;
  localparam int ADFL_BIT_LO = 1;
  localparam int ADFL_BIT_HI = 5;

  // implemented bits; bits 7, 6 and 0 read zero
  localparam logic [7:0] ADFL_IMPL_MASK = 8'h3E;

  // reset values
  localparam logic [7:0] ADFL_RST_MASK = 8'h00;
  localparam logic [7:0] ADFL_RST_FLAGS = 8'h00;
  localparam logic [7:0] ADFL_RST_RDATA = 8'h00;
  localparam logic ADFL_RST_BUS_LEVEL = 1'b1;

  // one register access after serial framing
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } adfl_req_t;

  // analog detector levels, one cycle synchronous to the clock
  typedef struct packed {
    logic supply_low;
    logic supply_high;
    logic overtemp;
    logic hb_overcurrent;
    logic reg_overcurrent;
  } adfl_detect_t;

endpackage : adfl_pkg

// >>> design/adfl_flag_cell.sv
`timescale 1ns/1ps
`default_nettype none
module adfl_flag_cell (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controls
  input wire logic sync_clr,
  input wire logic set,
  input wire logic clr,
  // state
  output logic q
);

  logic next_q;

  // set beats clear so an event in the clearing cycle is kept
  assign next_q = sync_clr ? 1'b0 : (set | (q & ~clr));

  // sticky flag storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

endmodule : adfl_flag_cell
`default_nettype wire

// >>> design/adfl_top.sv
`timescale 1ns/1ps
`default_nettype none
module adfl_top
  import adfl_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register access port
  input wire adfl_req_t REQ,
  output logic [7:0] RDATA,
  output logic RVALID,
  // detector inputs
  input wire adfl_detect_t DETECT,
  input wire logic BUS_RX,
  input wire logic OC_STATUS_CLEAR,
  // internal reset sources
  input wire logic INT_RESET_REQ,
  // shared reset line
  input wire logic RST_LINE_IN,
  output logic RST_LINE_OUT,
  output logic RST_LINE_OE,
  // interrupt request line
  output logic IRQ_N_OUT,
  output logic IRQ_N_OE,
  // power stage control
  output logic HIGH_SIDE_OFF
);

  // register hit decode
  function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // unused bit positions always read and store zero
  function automatic logic [7:0] impl_bits(input logic [7:0] v);
    impl_bits = v & ADFL_IMPL_MASK;
  endfunction : impl_bits

  // place the five per-source bits at their shared field positions
  function automatic logic [7:0] pack_sources(
    input logic bus_edge,
    input logic overtemp,
    input logic supply_low,
    input logic supply_high,
    input logic overcurrent
  );
    logic [7:0] v;
    v = 8'h00;
    v[ADFL_BIT_BUS_EDGE] = bus_edge;
    v[ADFL_BIT_OVERTEMP] = overtemp;
    v[ADFL_BIT_SUPPLY_LOW] = supply_low;
    v[ADFL_BIT_SUPPLY_HIGH] = supply_high;
    v[ADFL_BIT_OVERCURRENT] = overcurrent;
    pack_sources = v;
  endfunction : pack_sources

  logic bus_level;
  logic [7:0] interrupt_mask;
  logic [7:0] flag_q;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] cond_now;
  logic [7:0] wr_one;
  logic [7:0] interrupt_flags;
  logic [7:0] next_mask;
  logic [7:0] next_rdata;
  logic line_reset;
  logic hit_mask;
  logic hit_flags;
  logic bus_fall;
  logic overcurrent;
  logic any_pending;
  logic next_irq_oe;
  logic next_hs_off;

  // next values of the read and edge registers
  logic next_rvalid;
  logic next_bus_level;
  logic [7:0] next_read_word;

  // write strobes and read selects
  logic wr_mask;
  logic wr_flags;
  logic rd_sel_mask;
  logic rd_sel_flags;

  // per-source set terms
  logic set_bus_edge;
  logic set_overtemp;
  logic set_supply_low;
  logic set_supply_high;
  logic set_overcurrent;

  // per-source clear terms
  logic clr_bus_edge;
  logic clr_overtemp;
  logic clr_supply_low;
  logic clr_supply_high;
  logic clr_overcurrent;

  // conditions that hold back a clear
  logic hold_overtemp;
  logic hold_supply_low;
  logic hold_supply_high;

  // per-source enables and pending terms
  logic en_bus_edge;
  logic en_overtemp;
  logic en_supply_low;
  logic en_supply_high;
  logic en_overcurrent;
  logic pend_bus_edge;
  logic pend_overtemp;
  logic pend_supply_low;
  logic pend_supply_high;
  logic pend_overcurrent;

  // supply fault terms for the power stage
  logic supply_fault;
  logic latched_supply_fault;

  // request decode
  assign hit_mask = reg_hit(REQ.addr, ADFL_OFS_MASK);
  assign hit_flags = reg_hit(REQ.addr, ADFL_OFS_FLAGS);
  assign wr_mask = REQ.wr & hit_mask;
  assign wr_flags = REQ.wr & hit_flags;
  assign wr_one = wr_flags ? REQ.wdata : 8'h00;

  // line held low by either side clears flags and enables
  assign line_reset = ~RST_LINE_IN;
  assign RST_LINE_OUT = 1'b0;
  assign RST_LINE_OE = INT_RESET_REQ;

  // source conditions
  assign bus_fall = bus_level & ~BUS_RX;
  assign next_bus_level = BUS_RX;
  assign overcurrent = DETECT.hb_overcurrent | DETECT.reg_overcurrent;

  // bus line falling edge source
  assign set_bus_edge = bus_fall;
  assign clr_bus_edge = wr_one[ADFL_BIT_BUS_EDGE];
  assign en_bus_edge = interrupt_mask[ADFL_BIT_BUS_EDGE];
  assign pend_bus_edge = flag_q[ADFL_BIT_BUS_EDGE] & en_bus_edge;

  // overtemperature source, clear held back while hot
  assign hold_overtemp = DETECT.overtemp;
  assign set_overtemp = DETECT.overtemp;
  assign clr_overtemp = wr_one[ADFL_BIT_OVERTEMP] &
                        ~cond_now[ADFL_BIT_OVERTEMP];
  assign en_overtemp = interrupt_mask[ADFL_BIT_OVERTEMP];
  assign pend_overtemp = flag_q[ADFL_BIT_OVERTEMP] & en_overtemp;

  // supply low source, clear held back while low
  assign hold_supply_low = DETECT.supply_low;
  assign set_supply_low = DETECT.supply_low;
  assign clr_supply_low = wr_one[ADFL_BIT_SUPPLY_LOW] &
                          ~cond_now[ADFL_BIT_SUPPLY_LOW];
  assign en_supply_low = interrupt_mask[ADFL_BIT_SUPPLY_LOW];
  assign pend_supply_low = flag_q[ADFL_BIT_SUPPLY_LOW] & en_supply_low;

  // supply high source, clear held back while high
  assign hold_supply_high = DETECT.supply_high;
  assign set_supply_high = DETECT.supply_high;
  assign clr_supply_high = wr_one[ADFL_BIT_SUPPLY_HIGH] &
                           ~cond_now[ADFL_BIT_SUPPLY_HIGH];
  assign en_supply_high = interrupt_mask[ADFL_BIT_SUPPLY_HIGH];
  assign pend_supply_high = flag_q[ADFL_BIT_SUPPLY_HIGH] & en_supply_high;

  // overcurrent source, cleared from the status side or by a low reset line, not by a register write
  assign set_overcurrent = overcurrent;
  assign clr_overcurrent = OC_STATUS_CLEAR;
  assign en_overcurrent = interrupt_mask[ADFL_BIT_OVERCURRENT];
  assign pend_overcurrent = flag_q[ADFL_BIT_OVERCURRENT] & en_overcurrent;

  // present condition per bit, used to block clears
  assign cond_now = pack_sources(1'b0, hold_overtemp, hold_supply_low,
                                 hold_supply_high, 1'b0);

  // set and clear vectors at the shared field positions
  assign flag_set = pack_sources(set_bus_edge, set_overtemp, set_supply_low,
                                 set_supply_high, set_overcurrent);
  assign flag_clr = pack_sources(clr_bus_edge, clr_overtemp, clr_supply_low,
                                 clr_supply_high, clr_overcurrent);

  // one sticky cell per implemented flag

  // bus edge flag cell
  adfl_flag_cell u_bus_edge_cell (
    .clk(CLK),
    .rst_n(RST_N),
    .sync_clr(line_reset),
    .set(flag_set[ADFL_BIT_BUS_EDGE]),
    .clr(flag_clr[ADFL_BIT_BUS_EDGE]),
    .q(flag_q[ADFL_BIT_BUS_EDGE])
  );

  // overtemperature flag cell
  adfl_flag_cell u_overtemp_cell (
    .clk(CLK),
    .rst_n(RST_N),
    .sync_clr(line_reset),
    .set(flag_set[ADFL_BIT_OVERTEMP]),
    .clr(flag_clr[ADFL_BIT_OVERTEMP]),
    .q(flag_q[ADFL_BIT_OVERTEMP])
  );

  // supply low flag cell
  adfl_flag_cell u_supply_low_cell (
    .clk(CLK),
    .rst_n(RST_N),
    .sync_clr(line_reset),
    .set(flag_set[ADFL_BIT_SUPPLY_LOW]),
    .clr(flag_clr[ADFL_BIT_SUPPLY_LOW]),
    .q(flag_q[ADFL_BIT_SUPPLY_LOW])
  );

  // supply high flag cell
  adfl_flag_cell u_supply_high_cell (
    .clk(CLK),
    .rst_n(RST_N),
    .sync_clr(line_reset),
    .set(flag_set[ADFL_BIT_SUPPLY_HIGH]),
    .clr(flag_clr[ADFL_BIT_SUPPLY_HIGH]),
    .q(flag_q[ADFL_BIT_SUPPLY_HIGH])
  );

  // overcurrent flag cell
  adfl_flag_cell u_overcurrent_cell (
    .clk(CLK),
    .rst_n(RST_N),
    .sync_clr(line_reset),
    .set(flag_set[ADFL_BIT_OVERCURRENT]),
    .clr(flag_clr[ADFL_BIT_OVERCURRENT]),
    .q(flag_q[ADFL_BIT_OVERCURRENT])
  );
  assign flag_q[7:6] = 2'b00;
  assign flag_q[0] = 1'b0;

  // visible flag register, unused bits zero
  assign interrupt_flags = impl_bits(flag_q);

  // mask register update
  assign next_mask = line_reset ? ADFL_RST_MASK :
                     wr_mask ? impl_bits(REQ.wdata) :
                     interrupt_mask;

  // read mux, unmapped addresses read zero
  assign rd_sel_mask = REQ.rd & hit_mask;
  assign rd_sel_flags = REQ.rd & hit_flags;
  assign next_rdata = rd_sel_mask ? impl_bits(interrupt_mask) :
                      rd_sel_flags ? interrupt_flags : 8'h00;
  assign next_read_word = REQ.rd ? next_rdata : RDATA;
  assign next_rvalid = REQ.rd;

  // any enabled flag pulls the request line
  assign any_pending = pend_bus_edge | pend_overtemp | pend_supply_low |
                       pend_supply_high | pend_overcurrent;
  assign next_irq_oe = any_pending & ~line_reset;

  // supply faults, live or latched, switch the high sides off
  assign supply_fault = DETECT.supply_low | DETECT.supply_high;
  assign latched_supply_fault = flag_q[ADFL_BIT_SUPPLY_LOW] | flag_q[ADFL_BIT_SUPPLY_HIGH];
  assign next_hs_off = supply_fault | latched_supply_fault;

  // open drain request only ever pulls low
  assign IRQ_N_OUT = 1'b0;

  // enable storage
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      interrupt_mask <= ADFL_RST_MASK;
    end else begin
      interrupt_mask <= next_mask;
    end
  end

  // previous bus level for edge detection
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_level <= ADFL_RST_BUS_LEVEL;
    end else begin
      bus_level <= next_bus_level;
    end
  end

  // read data, one cycle after the request, held until the next read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= ADFL_RST_RDATA;
    end else begin
      RDATA <= next_read_word;
    end
  end

  // read answer strobe, one cycle long
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RVALID <= 1'b0;
    end else begin
      RVALID <= next_rvalid;
    end
  end

  // request line enable, high while pulling low
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ_N_OE <= 1'b0;
    end else begin
      IRQ_N_OE <= next_irq_oe;
    end
  end

  // high-side switch-off level
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HIGH_SIDE_OFF <= 1'b0;
    end else begin
      HIGH_SIDE_OFF <= next_hs_off;
    end
  end

endmodule : adfl_top
`default_nettype wire

// >>> tb/adfl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adfl_chk
  import adfl_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire adfl_req_t REQ,
  input wire logic [7:0] RDATA,
  input wire logic RVALID,
  // events and lines
  input wire adfl_detect_t DETECT,
  input wire logic INT_RESET_REQ,
  input wire logic RST_LINE_IN,
  input wire logic RST_LINE_OE,
  input wire logic IRQ_N_OUT,
  input wire logic IRQ_N_OE,
  input wire logic HIGH_SIDE_OFF
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // read answers and reserved bits
  rd_answer_a: assert property (REQ.rd |=> RVALID)
    else $error("read not answered");
  rd_idle_a: assert property (!REQ.rd |=> !RVALID)
    else $error("answer without read");
  rd_zero_a: assert property (RVALID |-> (RDATA & 8'hC1) == 8'h00)
    else $error("reserved bit reads one");
  // request line only ever pulls low; reset line enable follows the internal request
  irq_drive_a: assert property (IRQ_N_OUT == 1'h0)
    else $error("request line driven high");
  rst_drive_a: assert property (RST_LINE_OE == INT_RESET_REQ)
    else $error("reset line enable wrong");
  // supply events turn the high sides off; a low reset line drops the request
  low_off_a: assert property (DETECT.supply_low |=> HIGH_SIDE_OFF)
    else $error("high sides on at low supply");
  high_off_a: assert property (DETECT.supply_high |=> HIGH_SIDE_OFF)
    else $error("high sides on at high supply");
  off_cause_a: assert property (!HIGH_SIDE_OFF && !DETECT.supply_low && !DETECT.supply_high
    |=> !HIGH_SIDE_OFF)
    else $error("high sides off without cause");
  line_clear_a: assert property (!RST_LINE_IN |=> !IRQ_N_OE)
    else $error("request kept through reset");
  // main scenarios reached
  cover property (RVALID);
  cover property (IRQ_N_OE);
  cover property (HIGH_SIDE_OFF);
endmodule : adfl_chk
bind adfl_top adfl_chk adfl_chk_inst (.CLK(CLK), .RST_N(RST_N), .REQ(REQ), .RDATA(RDATA),
  .RVALID(RVALID), .DETECT(DETECT), .INT_RESET_REQ(INT_RESET_REQ), .RST_LINE_IN(RST_LINE_IN),
  .RST_LINE_OE(RST_LINE_OE), .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE(IRQ_N_OE),
  .HIGH_SIDE_OFF(HIGH_SIDE_OFF));
`default_nettype wire

// >>> tb/adfl_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module adfl_mcu_model (
  // device side pins
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic rst_out,
  input wire logic rst_oe,
  // resolved lines
  output logic irq_n,
  output logic rst_line
);
  // open-drain wires idle high through the pull-ups
  assign irq_n = irq_oe ? irq_out : 1'h1;
  assign rst_line = rst_oe ? rst_out : 1'h1;
endmodule : adfl_mcu_model
`default_nettype wire

// >>> tb/adfl_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module adfl_top_test import adfl_pkg::*;;
  logic clk = 1'h0, rst_n = 1'h0, bus_rx = 1'h1, oc_clr = 1'h0, int_rst = 1'h0;
  adfl_req_t req = '0;
  adfl_detect_t det = '0;
  logic [7:0] rdata;
  logic rvalid, rst_out, rst_oe, irq_out, irq_oe, hs_off, irq_n, rst_line;
  int bad_count = 0, cmp_count = 0, r;
  logic [7:0] exp_q[$];
  logic [7:0] fb[3] = '{8'h08, 8'h04, 8'h10};
  // clock
  initial forever #2 clk = ~clk;
  adfl_top adfl_top_inst (.CLK(clk), .RST_N(rst_n), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
    .DETECT(det), .BUS_RX(bus_rx), .OC_STATUS_CLEAR(oc_clr), .INT_RESET_REQ(int_rst),
    .RST_LINE_IN(rst_line), .RST_LINE_OUT(rst_out), .RST_LINE_OE(rst_oe),
    .IRQ_N_OUT(irq_out), .IRQ_N_OE(irq_oe), .HIGH_SIDE_OFF(hs_off));
  adfl_mcu_model adfl_mcu_model_inst (.irq_out(irq_out), .irq_oe(irq_oe), .rst_out(rst_out),
    .rst_oe(rst_oe), .irq_n(irq_n), .rst_line(rst_line));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_pin(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_pin
  // one access; for a read d is the expected answer
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{w, !w, a, d};
    if (!w) exp_q.push_back(d);
    @(negedge clk);
    req <= '0;
  endtask : acc
  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // read answers against the oldest note
  always @(negedge clk) if (rvalid === 1'h1) chk(rdata, exp_q.pop_front());
  // watchdog
  initial begin
    #4000;
    bad_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    r = $urandom(45);
    repeat (3) @(negedge clk);
    rst_n <= 1'h1;
    acc(1'h0, ADFL_OFS_MASK, 8'h00);
    acc(1'h0, ADFL_OFS_FLAGS, 8'h00);
    r = $urandom;
    acc(1'h1, ADFL_OFS_MASK, r[7:0]);
    acc(1'h0, ADFL_OFS_MASK, r[7:0] & 8'h3E);
    acc(1'h0, 5'h1F, 8'h00);
    acc(1'h1, ADFL_OFS_MASK, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      det[4-i] <= 1'h1;
      acc(1'h1, ADFL_OFS_FLAGS, fb[i]);
      acc(1'h0, ADFL_OFS_FLAGS, fb[i]);
      chk_pin(irq_n, 1'h0);
      chk_pin(hs_off, i < 2);
      det[4-i] <= 1'h0;
      acc(1'h1, ADFL_OFS_FLAGS, fb[i]);
      acc(1'h0, ADFL_OFS_FLAGS, 8'h00);
      chk_pin(irq_n, 1'h1);
      chk_pin(hs_off, 1'h0);
    end
    bus_rx <= 1'h0;
    acc(1'h1, ADFL_OFS_FLAGS, 8'h00);
    acc(1'h0, ADFL_OFS_FLAGS, 8'h20);
    chk_pin(irq_n, 1'h0);
    acc(1'h1, ADFL_OFS_FLAGS, 8'h20);
    acc(1'h0, ADFL_OFS_FLAGS, 8'h00);
    det[1] <= 1'h1;
    acc(1'h1, ADFL_OFS_FLAGS, 8'h02);
    det[1] <= 1'h0;
    acc(1'h0, ADFL_OFS_FLAGS, 8'h02);
    oc_clr <= 1'h1;
    @(negedge clk);
    oc_clr <= 1'h0;
    acc(1'h0, ADFL_OFS_FLAGS, 8'h00);
    int_rst <= 1'h1;
    @(negedge clk);
    int_rst <= 1'h0;
    acc(1'h0, ADFL_OFS_MASK, 8'h00);
    repeat (2) @(negedge clk);
    chk(8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule : adfl_top_test
`default_nettype wire
